// *** design/ccif_cmp_match.sv ***
// ccif_cmp_match.sv: one compare channel, a pulse on the onset of a match.
// assumes count and value are on aclk; aresetn synchronous, active low.
module ccif_cmp_match #(
	parameter int unsigned W = 16
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] count,
	input  wire logic [W-1:0] value,
	input  wire logic         enable,
	output logic              match_pulse
);
	logic match_now;
	logic match_q;

	// a held match yields one pulse, so a cleared flag stays clear
	assign match_now = enable && (count == value);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_q     <= 1'b0;
			match_pulse <= 1'b0;
		end else begin
			match_q     <= match_now;
			match_pulse <= match_now && !match_q;
		end
	end

endmodule // ccif_cmp_match

// *** design/ccif_pkg.sv ***
// ccif_pkg.sv: constants shared by the capture/compare interrupt flag block.
// assumes nothing beyond a SystemVerilog compiler.
package ccif_pkg;

	// ======================================================================
	// widths
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned FLAG_W  = 8;
	localparam int unsigned CODE_W  = 3;
	localparam int unsigned CMP_W   = 16;
	localparam int unsigned NUM_CMP = 4;
	localparam int unsigned IDX_W   = 8;
	localparam int unsigned IDX_LSB = 2;

	// ======================================================================
	// register indices, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_ENABLE   = 8'hC9;
	localparam logic [IDX_W-1:0] IDX_FLAG     = 8'hE9;
	localparam logic [IDX_W-1:0] IDX_CODE     = 8'hDE;
	localparam logic [IDX_W-1:0] IDX_CTRL     = 8'hF0;
	localparam logic [IDX_W-1:0] IDX_CMP_EN   = 8'hF1;
	localparam logic [IDX_W-1:0] IDX_CMP_VAL0 = 8'hF2;
	localparam logic [IDX_W-1:0] IDX_TIMER    = 8'hF6;

	// ======================================================================
	// bit positions in flag and enable registers
	localparam int unsigned BIT_CAP_A = 0;
	localparam int unsigned BIT_CAP_B = 1;
	localparam int unsigned BIT_RSVD  = 2;
	localparam int unsigned BIT_CMP_A = 3;
	localparam int unsigned BIT_OVF   = 7;
	localparam logic [FLAG_W-1:0] DEFINED_MASK = 8'hFB;

	// control register bits
	localparam int unsigned BIT_GLOBAL_EN = 0;
	localparam int unsigned BIT_UNIT_EN   = 1;

	// ======================================================================
	// reset values
	localparam logic [FLAG_W-1:0]  FLAG_RST    = 8'h00;
	localparam logic [FLAG_W-1:0]  ENABLE_RST  = 8'h00;
	localparam logic [NUM_CMP-1:0] CMP_EN_RST  = 4'h0;
	localparam logic [CMP_W-1:0]   CMP_VAL_RST = 16'h0000;

	// ======================================================================
	// event codes
	localparam logic [CODE_W-1:0] CODE_NONE  = 3'h0;
	localparam logic [CODE_W-1:0] CODE_CMP_A = 3'h4;
	localparam logic [CODE_W-1:0] CODE_CAP_B = 3'h5;
	localparam logic [CODE_W-1:0] CODE_CAP_A = 3'h6;
	localparam logic [CODE_W-1:0] CODE_OVF   = 3'h7;

	// ======================================================================
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage // ccif_pkg

// *** design/ccif_prio_enc.sv ***
// ccif_prio_enc.sv: fixed-priority encoder of the pending sources.
// assumes pending flags are already masked by their enables.
module ccif_prio_enc (
	input  wire logic [ccif_pkg::FLAG_W-1:0] pending,
	output logic      [ccif_pkg::CODE_W-1:0] code
);
	import ccif_pkg::*;

	// later assignments win: lowest priority first
	always_comb begin
		code = CODE_NONE;
		for (int i = NUM_CMP - 1; i >= 0; i--) begin
			if (pending[BIT_CMP_A + i]) begin
				code = CODE_CMP_A - CODE_W'(i); // RL12 RL13
			end
		end
		if (pending[BIT_CAP_B]) begin
			code = CODE_CAP_B; // RL12 RL13
		end
		if (pending[BIT_CAP_A]) begin
			code = CODE_CAP_A; // RL12 RL13
		end
		if (pending[BIT_OVF]) begin
			code = CODE_OVF; // RL12 RL13
		end
	end

endmodule // ccif_prio_enc

// *** design/ccif_top.sv ***
// ccif_top.sv: interrupt flags, enables and event code of the capture/compare
//   unit, reached over an AXI4-Lite slave.
// assumes event pulses and timer count come from logic on aclk.
//
// Chosen here: register access over AXI4-Lite.

// Functional notes
// (RL1) capture A event sets flag bit 0
// (RL2) capture B event sets flag bit 1
// (RL3) software never writes one to bit 2
// (RL4) compare A match sets flag bit 3
// (RL5) compare B, C, D matches set bits 4-6
// (RL6) timer overflow sets flag bit 7
// (RL7) compare request needs global, unit, channel enable
// (RL8) capture enables in enable bits 0 and 1
// (RL9) compare enables in enable bits 3 to 6
// (RL10) overflow enable in enable bit 7
// (RL11) flags AND enables form one request
// (RL12) fixed priority overflow, captures, compares A-D
// (RL13) three-bit code reports highest pending source
// (RL14) writing zero clears exactly that flag
// (RL15) hardware set beats software clear
// (RL16) reset clears flags, enables; reserved reads zero
module ccif_top #(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	input  wire logic [ccif_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [ccif_pkg::DATA_W/8-1:0] s_axi_wstrb,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	output logic      [1:0]                    s_axi_bresp,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	input  wire logic [ADDR_W-1:0]             s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	output logic      [ccif_pkg::DATA_W-1:0]   s_axi_rdata,
	output logic      [1:0]                    s_axi_rresp,
	input  wire logic                          capture_a_event,
	input  wire logic                          capture_b_event,
	input  wire logic                          overflow_event,
	input  wire logic [ccif_pkg::CMP_W-1:0]    timer_count,
	output logic                               irq_request,
	output logic      [ccif_pkg::CODE_W-1:0]   event_code
);
	import ccif_pkg::*;

	localparam int unsigned TOP_LSB = IDX_LSB + IDX_W;

	// ======================================================================
	// elaboration checks
	if (ADDR_W <= TOP_LSB) begin : g_bad_addr_w
		$error("ADDR_W too small for the register indices");
	end
	if (CMP_W != 16) begin : g_bad_cmp_w
		$error("compare values are written in two byte lanes");
	end
	if (BIT_CMP_A + NUM_CMP != BIT_OVF) begin : g_bad_layout
		$error("compare flags must fill the bits below overflow");
	end
	if (IDX_CMP_VAL0 + NUM_CMP > IDX_TIMER) begin : g_bad_map
		$error("compare value indices run into the timer index");
	end

	// ======================================================================
	// declarations
	logic                  aw_hold_q;
	logic                  w_hold_q;
	logic [ADDR_W-1:0]     awaddr_q;
	logic [DATA_W-1:0]     wdata_q;
	logic [DATA_W/8-1:0]   wstrb_q;
	logic                  bvalid_q;
	logic [1:0]            bresp_q;
	logic                  rvalid_q;
	logic [DATA_W-1:0]     rdata_q;
	logic [1:0]            rresp_q;

	logic                  wr_fire;
	logic [IDX_W-1:0]      wr_idx;
	logic                  wr_hit;
	logic                  wr_ok;
	logic                  rd_take;
	logic [IDX_W-1:0]      rd_idx;
	logic                  rd_hit;
	logic [DATA_W-1:0]     rd_word;

	logic [FLAG_W-1:0]     flags_q;
	logic [FLAG_W-1:0]     enable_q;
	logic                  global_en_q;
	logic                  unit_en_q;
	logic [NUM_CMP-1:0]    cmp_en_q;
	logic [CMP_W-1:0]      cmp_val_q [NUM_CMP];
	logic [NUM_CMP-1:0]    cmp_pulse;

	logic [FLAG_W-1:0]     set_vec;
	logic [FLAG_W-1:0]     clr_vec;
	logic [FLAG_W-1:0]     flags_d;
	logic [FLAG_W-1:0]     pending;
	logic [CODE_W-1:0]     code_d;
	logic [CODE_W-1:0]     event_code_q;
	logic                  irq_q;

	// ======================================================================
	// address decode
	function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
		logic hit;
		hit = (idx == IDX_ENABLE) || (idx == IDX_FLAG) || (idx == IDX_CODE) ||
			(idx == IDX_CTRL) || (idx == IDX_CMP_EN) || (idx == IDX_TIMER);
		if ((idx >= IDX_CMP_VAL0) && (idx < IDX_CMP_VAL0 + IDX_W'(NUM_CMP))) begin
			hit = 1'b1;
		end
		return hit;
	endfunction

	assign wr_idx = awaddr_q[IDX_LSB +: IDX_W];
	assign wr_hit = (awaddr_q[IDX_LSB-1:0] == '0) &&
		(awaddr_q[ADDR_W-1:TOP_LSB] == '0) && idx_mapped(wr_idx);
	assign wr_ok  = wr_fire && wr_hit;

	assign rd_idx = s_axi_araddr[IDX_LSB +: IDX_W];
	assign rd_hit = (s_axi_araddr[IDX_LSB-1:0] == '0) &&
		(s_axi_araddr[ADDR_W-1:TOP_LSB] == '0) && idx_mapped(rd_idx);

	// ======================================================================
	// write channel
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready  = !w_hold_q && !bvalid_q;
	assign wr_fire       = aw_hold_q && w_hold_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			awaddr_q  <= '0;
		end else if (wr_fire) begin
			aw_hold_q <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (wr_fire) begin
			w_hold_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_hold_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// ======================================================================
	// read channel
	assign s_axi_arready = !rvalid_q;
	assign rd_take       = s_axi_arvalid && s_axi_arready;

	always_comb begin
		rd_word = '0;
		case (rd_idx)
			IDX_ENABLE: rd_word = DATA_W'(enable_q);
			IDX_FLAG:   rd_word = DATA_W'(flags_q);
			IDX_CODE:   rd_word = DATA_W'(event_code_q); // RL13
			IDX_CTRL: begin
				rd_word[BIT_GLOBAL_EN] = global_en_q;
				rd_word[BIT_UNIT_EN]   = unit_en_q;
			end
			IDX_CMP_EN: rd_word = DATA_W'(cmp_en_q);
			IDX_TIMER:  rd_word = DATA_W'(timer_count);
			default: begin
				for (int i = 0; i < NUM_CMP; i++) begin
					if (rd_idx == IDX_CMP_VAL0 + IDX_W'(i)) begin
						rd_word = DATA_W'(cmp_val_q[i]);
					end
				end
			end
		endcase
		if (!rd_hit) begin
			rd_word = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= '0;
			rresp_q  <= RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// ======================================================================
	// enable and control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable_q <= ENABLE_RST; // RL16
		end else if (wr_ok && (wr_idx == IDX_ENABLE) && wstrb_q[0]) begin
			// reserved position forced low whatever is written
			enable_q <= wdata_q[FLAG_W-1:0] & DEFINED_MASK; // RL3 RL8 RL9 RL10
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			global_en_q <= 1'b0;
			unit_en_q   <= 1'b0;
		end else if (wr_ok && (wr_idx == IDX_CTRL) && wstrb_q[0]) begin
			global_en_q <= wdata_q[BIT_GLOBAL_EN];
			unit_en_q   <= wdata_q[BIT_UNIT_EN];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmp_en_q <= CMP_EN_RST;
		end else if (wr_ok && (wr_idx == IDX_CMP_EN) && wstrb_q[0]) begin
			cmp_en_q <= wdata_q[NUM_CMP-1:0];
		end
	end

	// ======================================================================
	// compare channels
	for (genvar ch = 0; ch < NUM_CMP; ch++) begin : g_cmp
		localparam logic [IDX_W-1:0] CH_IDX = IDX_CMP_VAL0 + IDX_W'(ch);

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cmp_val_q[ch] <= CMP_VAL_RST;
			end else if (wr_ok && (wr_idx == CH_IDX)) begin
				if (wstrb_q[0]) begin
					cmp_val_q[ch][7:0] <= wdata_q[7:0];
				end
				if (wstrb_q[1]) begin
					cmp_val_q[ch][15:8] <= wdata_q[15:8];
				end
			end
		end

		ccif_cmp_match #(
			.W (CMP_W)
		) u_match (
			.aclk        (aclk),
			.aresetn     (aresetn),
			.count       (timer_count),
			.value       (cmp_val_q[ch]),
			.enable      (cmp_en_q[ch]),
			.match_pulse (cmp_pulse[ch])
		); // RL4 RL5
	end

	// ======================================================================
	// flag register
	always_comb begin
		set_vec                = '0;
		set_vec[BIT_CAP_A]     = capture_a_event; // RL1
		set_vec[BIT_CAP_B]     = capture_b_event; // RL2
		set_vec[BIT_OVF]       = overflow_event; // RL6
		for (int i = 0; i < NUM_CMP; i++) begin
			set_vec[BIT_CMP_A + i] = cmp_pulse[i]; // RL4 RL5
		end
	end

	always_comb begin
		clr_vec = '0;
		if (wr_ok && (wr_idx == IDX_FLAG) && wstrb_q[0]) begin
			clr_vec = ~wdata_q[FLAG_W-1:0] & DEFINED_MASK; // RL14
		end
	end

	// set is ORed after the clear so a coincident event survives
	for (genvar b = 0; b < FLAG_W; b++) begin : g_flag
		if (DEFINED_MASK[b]) begin : g_used
			assign flags_d[b] = (flags_q[b] && !clr_vec[b]) || set_vec[b]; // RL15
		end else begin : g_rsvd
			assign flags_d[b] = 1'b0; // RL16
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_q <= FLAG_RST; // RL16
		end else begin
			flags_q <= flags_d; // RL1 RL2 RL4 RL5 RL6 RL14 RL15
		end
	end

	// ======================================================================
	// request and event code
	assign pending = flags_q & enable_q; // RL11 RL8 RL9 RL10

	ccif_prio_enc u_prio (
		.pending (pending),
		.code    (code_d)
	); // RL12 RL13

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_code_q <= CODE_NONE;
		end else begin
			event_code_q <= code_d; // RL13
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= global_en_q && unit_en_q && (|pending); // RL7 RL8 RL9 RL11
		end
	end

	assign irq_request = irq_q;
	assign event_code  = event_code_q;

endmodule // ccif_top

// *** testbench/capture_compare_irq_flags_test.sv ***
// capture_compare_irq_flags_test.sv: self-checking bench for ccif_top.
// assumes ccif_pkg, ccif_top and the event source model are compiled first.
module capture_compare_irq_flags_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ccif_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, load = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_request;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] event_code, req = 3'h0;
	logic [15:0] load_val = 16'h0, timer_count, v;
	logic [7:0] fl = 8'h00;
	logic [3:0] strb = 4'hF;
	logic capture_a_event, capture_b_event, overflow_event;
	int err_total = 0, n_compared = 0, cycles = 0;
	integer seed = 69;
	logic [33:0] rq[$];
	logic [1:0] bq[$];

	ccif_top #(.ADDR_W(12)) ccif_top_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
		.s_axi_wstrb(strb), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
		.s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
		.s_axi_rdata, .s_axi_rresp, .capture_a_event, .capture_b_event, .overflow_event,
		.timer_count, .irq_request, .event_code);
	ccif_evt_src ccif_evt_src_inst (.aclk, .aresetn, .req, .run, .load, .load_val,
		.capture_a_event, .capture_b_event, .overflow_event, .timer_count);

	always #2.5 aclk = ~aclk;

	// ======================================================================
	// tasks
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [33:0] e, input logic [33:0] s);
		n_compared++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		bq.push_back(r);
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr  <= a;
		s_axi_wvalid  <= 1'b1;
		s_axi_wdata   <= d;
		s_axi_bready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		rq.push_back({r, d});
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr  <= a;
		s_axi_rready  <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic fire(input logic [2:0] m);
		@(posedge aclk);
		req <= m;
		@(posedge aclk);
		req <= 3'h0;
	endtask
	task automatic ld(input logic [15:0] x);
		@(posedge aclk);
		load     <= 1'b1;
		load_val <= x;
		@(posedge aclk);
		load <= 1'b0;
	endtask
	task automatic ci(input logic [2:0] c, input logic q);
		cyc(4);
		chk("event_code", {31'h0, c}, {31'h0, event_code});
		chk("irq_request", {33'h0, q}, {33'h0, irq_request});
	endtask

	// ======================================================================
	// response monitor and timeout
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			chk("write resp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			conclude;
		end
	end

	// ======================================================================
	// scenarios
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ad(IDX_ENABLE), 32'h0);
		rd(ad(IDX_FLAG), 32'h0);
		rd(ad(IDX_CODE), 32'h0);
		rd(ad(8'h00), 32'h0, RESP_SLVERR);
		fire(3'h1);
		ci(CODE_NONE, 1'b0);
		rd(ad(IDX_FLAG), 32'h01);
		wr(ad(IDX_ENABLE), 32'hFB);
		rd(ad(IDX_ENABLE), 32'hFB);
		ci(CODE_CAP_A, 1'b0);
		wr(ad(IDX_CTRL), 32'h1);
		ci(CODE_CAP_A, 1'b0);
		wr(ad(IDX_CTRL), 32'h3);
		ci(CODE_CAP_A, 1'b1);
		fire(3'h2);
		rd(ad(IDX_FLAG), 32'h03);
		ci(CODE_CAP_A, 1'b1);
		ld(16'hFFFD);
		run <= 1'b1;
		cyc(6);
		run <= 1'b0;
		rd(ad(IDX_FLAG), 32'h83);
		ci(CODE_OVF, 1'b1);
		wr(ad(IDX_ENABLE), 32'h7B);
		ci(CODE_CAP_A, 1'b1);
		wr(ad(IDX_ENABLE), 32'hFB);
		wr(ad(IDX_FLAG), 32'h7F);
		rd(ad(IDX_FLAG), 32'h03);
		fork
			wr(ad(IDX_FLAG), 32'h02);
			fire(3'h5);
		join
		rd(ad(IDX_FLAG), 32'h83);
		wr(ad(IDX_FLAG), 32'h00);
		ci(CODE_NONE, 1'b0);
		wr(ad(IDX_ENABLE) + 12'h001, 32'h00, RESP_SLVERR);
		strb <= 4'h0;
		wr(ad(IDX_ENABLE), 32'h00);
		strb <= 4'hF;
		rd(ad(IDX_ENABLE), 32'hFB);
		ld(16'hFFF0);
		wr(ad(IDX_CMP_EN), 32'hF);
		for (int i = 3; i >= 0; i--) begin
			v = {8'($random(seed)), 8'(i + 1)};
			wr(ad(IDX_CMP_VAL0 + 8'(i)), {16'h0, v});
			ld(v);
			rd(ad(IDX_TIMER), {16'h0, v});
			fl = fl | 8'(1 << (3 + i));
			rd(ad(IDX_FLAG), {24'h0, fl});
			ci(3'(4 - i), 1'b1);
		end
		wr(ad(IDX_ENABLE), 32'h40);
		ci(3'h1, 1'b1);
		aresetn <= 1'b0;
		cyc(2);
		aresetn <= 1'b1;
		rd(ad(IDX_ENABLE), 32'h0);
		rd(ad(IDX_FLAG), 32'h0);
		ci(CODE_NONE, 1'b0);
		wr(ad(IDX_CMP_VAL0), 32'h1234);
		ld(16'h1234);
		rd(ad(IDX_TIMER), 32'h1234);
		rd(ad(IDX_FLAG), 32'h0);
		conclude;
	end
endmodule // capture_compare_irq_flags_test

// *** testbench/ccif_evt_src.sv ***
// ccif_evt_src.sv: timer and capture event sources in front of the flags.
// assumes the bench requests pulses and timer loads on aclk.
module ccif_evt_src (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic [2:0]                 req,
	input wire logic                       run,
	input wire logic                       load,
	input wire logic [ccif_pkg::CMP_W-1:0] load_val,
	output logic                           capture_a_event,
	output logic                           capture_b_event,
	output logic                           overflow_event,
	output logic [ccif_pkg::CMP_W-1:0]     timer_count
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capture_a_event <= 1'b0;
			capture_b_event <= 1'b0;
		end else begin
			capture_a_event <= req[0];
			capture_b_event <= req[1];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_count    <= 16'h0000;
			overflow_event <= 1'b0;
		end else begin
			// one pulse on wrap, or on request
			overflow_event <= req[2] || (run && !load && timer_count == 16'hFFFF);
			if (load)
				timer_count <= load_val;
			else if (run)
				timer_count <= timer_count + 16'h0001;
		end
	end
endmodule // ccif_evt_src

// *** testbench/ccif_top_sva.sv ***
// ccif_top_sva.sv: bus and interrupt checks on the ports of ccif_top.
// assumes one clock aclk with synchronous active-low aresetn.
module ccif_top_sva
	import ccif_pkg::*;
#(
	parameter int unsigned ADDR_W = 12
) (
	input wire logic                        aclk,
	input wire logic                        aresetn,
	input wire logic                        s_axi_awvalid,
	input wire logic                        s_axi_awready,
	input wire logic                        s_axi_wvalid,
	input wire logic                        s_axi_wready,
	input wire logic                        s_axi_bvalid,
	input wire logic                        s_axi_bready,
	input wire logic                        s_axi_arvalid,
	input wire logic                        s_axi_arready,
	input wire logic [ADDR_W-1:0]           s_axi_araddr,
	input wire logic                        s_axi_rvalid,
	input wire logic [ccif_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0]                  s_axi_rresp,
	input wire logic                        irq_request,
	input wire logic [ccif_pkg::CODE_W-1:0] event_code
);
	timeunit 1ns;
	timeprecision 1ps;
	logic quiet;
	// no handshake, no write response: event code and request cannot fall at the next edge
	assign quiet = !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready)
		&& !(s_axi_wvalid && s_axi_wready);

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ======================================================================
	// bus
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == 8'h00
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response timing");

	// ======================================================================
	// interrupt
	irq_code_a: assert property (irq_request |-> event_code != CODE_NONE)
		else $error("request without pending source");
	code_rise_a: assert property (quiet |=> event_code >= $past(event_code))
		else $error("event code dropped without a write");
	irq_keep_a: assert property (quiet && irq_request |=> irq_request)
		else $error("request dropped without a write");

	cover property (irq_request && event_code == CODE_OVF);
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	cover property ($rose(irq_request));
endmodule // ccif_top_sva

bind ccif_top ccif_top_sva #(.ADDR_W(ADDR_W)) ccif_top_sva_inst (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
	.s_axi_rdata, .s_axi_rresp, .irq_request, .event_code);
